// *** design/uls_map.svh ***
// Register offsets, bit positions, reset values and sizes of the line status block
`ifndef ULS_MAP_SVH
`define ULS_MAP_SVH

// Host bus register offsets
`define ULS_ADDR_RX_HOLD     3'h0
`define ULS_ADDR_FCR         3'h2
`define ULS_ADDR_LINE_STATUS 3'h5

// line_status bit positions
`define ULS_LS_DATA_READY  0
`define ULS_LS_OVERRUN     1
`define ULS_LS_PARITY      2
`define ULS_LS_FRAMING     3
`define ULS_LS_BREAK       4
`define ULS_LS_HOLD_EMPTY  5
`define ULS_LS_TX_EMPTY    6
`define ULS_LS_FIFO_ERR    7

// FIFO control bit positions
`define ULS_FCR_EN       0
`define ULS_FCR_RX_RST   1

// Reset values and the stored break character
`define ULS_RST_RDATA    8'h00
`define ULS_RST_FIFO_EN  1'b0
`define ULS_RST_ERR_CNT  8'h00
`define ULS_BREAK_CHAR   8'h00

// Sizes
`define ULS_FIFO_DEPTH   4
`define ULS_ERR_W        8

`endif

// *** design/uls_pkg.sv ***
// Types shared by the line status block, the host model and the testbench
package uls_pkg;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uls_bus_req_t;

  typedef struct packed {
    logic       break_flag;
    logic       framing_flag;
    logic       parity_flag;
    logic [7:0] data;
  } uls_rx_char_t;

  typedef enum logic [2:0] {
    ULS_ACC_NONE,
    ULS_ACC_RD_HOLD,
    ULS_ACC_RD_STATUS,
    ULS_ACC_RD_OTHER,
    ULS_ACC_WR_FCR,
    ULS_ACC_WR_OTHER
  } uls_access_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       fifo_en;
    logic       overrun;
    logic [7:0] err_cnt;
  } uls_state_t;

endpackage

// *** design/uls_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps
module uls_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // Control
  input  wire logic                   flush,
  // Fill side
  input  wire logic                   in_valid,
  input  wire logic [WIDTH-1:0]       in_data,
  output      logic                   in_ready,
  // Drain side
  output      logic                   out_valid,
  output      logic [WIDTH-1:0]       out_data,
  input  wire logic                   out_ready,
  // Fill level
  output      logic [$clog2(DEPTH):0] count
);

  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally only for a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
    $error("uls_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rp;
    logic [AW-1:0]               wp;
    logic [AW:0]                 cnt;
  } uls_fifo_st_t;

  uls_fifo_st_t st;
  uls_fifo_st_t next_st;
  logic         do_push;
  logic         do_pop;

  assign in_ready  = st.cnt != (AW + 1)'(DEPTH);
  assign out_valid = st.cnt != '0;
  assign out_data  = st.mem[st.rp];
  assign count     = st.cnt;

  always_comb begin
    next_st = st;
    do_push = in_valid && in_ready;
    do_pop  = out_ready && out_valid;
    if (flush) begin
      next_st.rp  = '0;
      next_st.wp  = '0;
      next_st.cnt = '0;
    end else begin
      if (do_push) begin
        next_st.mem[st.wp] = in_data;
        next_st.wp         = st.wp + AW'(1);
      end
      if (do_pop) begin
        next_st.rp = st.rp + AW'(1);
      end
      next_st.cnt = st.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// *** design/uls_line_status.sv ***
// Line status logic of one serial channel: receive FIFO head flags and status read-back
//
// Contract
// - Bit 0 set while receive FIFO holds a character, clear when empty.
// - Bit 1 reports that a receive overrun has occurred.
// - Bit 2 shows parity flag of the character the host reads next.
// - Bit 3 shows framing flag (no valid stop bit) of next character.
// - Bit 4 shows break flag of next character; break stored as 00.
// - Bit 5 set while transmit holding stage is empty.
// - Bit 6 set only when holding stage and shift register both empty.
// - Bit 7 set while any FIFO character carries an error flag.
// - Status read bits 4:2 carry head character's break, framing, parity flags.
// - Bits 4:2 have no own storage; head flags feed those bits of the read data register.
// - Status read leaves receive FIFO read pointer unchanged.
// - Read pointer advances only on a receive holding register read.
// - After reset bits 7 and 4:0 all read 0.
// - FIFOs work only with FIFO enable bit set; disabled by default.
`timescale 1ns/1ps
`include "uls_map.svh"
module uls_line_status
  import uls_pkg::*;
#(
  parameter int DEPTH = `ULS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Host register bus
  input  wire uls_bus_req_t bus_req,
  output      logic [7:0]   bus_rdata,
  // Receiver character stream
  input  wire logic         rx_valid,
  input  wire uls_rx_char_t rx_char,
  // Transmitter status
  input  wire logic         tx_hold_empty,
  input  wire logic         tx_shift_empty,
  // Mode
  output      logic         fifo_enable
);

  localparam int CW = $clog2(DEPTH) + 1;

  // Error counter must be able to count every entry
  if (DEPTH < 2 || DEPTH > 255 || (DEPTH & (DEPTH - 1)) != 0) begin
    $error("uls_line_status: DEPTH must be a power of two from 2 to 128");
  end

  uls_state_t   st;
  uls_state_t   next_st;
  uls_access_t  acc;
  uls_rx_char_t head;
  uls_rx_char_t push_char;
  logic         head_valid;
  logic         fifo_in_ready;
  logic [CW-1:0] fifo_cnt;
  logic         accept;
  logic         push;
  logic         pop;
  logic         flush;
  logic         head_err;
  logic         push_err;
  logic         lost;

  // Access decode
  always_comb begin
    acc = ULS_ACC_NONE;
    if (bus_req.cs && bus_req.rd) begin
      case (bus_req.addr)
        `ULS_ADDR_RX_HOLD:     acc = ULS_ACC_RD_HOLD;
        `ULS_ADDR_LINE_STATUS: acc = ULS_ACC_RD_STATUS;
        default:       acc = ULS_ACC_RD_OTHER;
      endcase
    end else if (bus_req.cs && bus_req.wr) begin
      case (bus_req.addr)
        `ULS_ADDR_FCR: acc = ULS_ACC_WR_FCR;
        default:       acc = ULS_ACC_WR_OTHER;
      endcase
    end
  end

  // Receive FIFO control
  // Toggling the enable bit also empties the FIFO so no stale mode mix remains
  assign flush = (acc == ULS_ACC_WR_FCR) &&
                 (bus_req.wdata[`ULS_FCR_RX_RST] ||
                  (bus_req.wdata[`ULS_FCR_EN] != st.fifo_en));

  // With the FIFO off only a single holding entry is usable
  assign accept = fifo_in_ready && (st.fifo_en || !head_valid);
  assign push   = rx_valid && accept && !flush;
  assign lost   = rx_valid && !accept;
  assign pop    = (acc == ULS_ACC_RD_HOLD) && head_valid && !flush;

  always_comb begin
    push_char      = rx_char;
    if (rx_char.break_flag) begin
      push_char.data = `ULS_BREAK_CHAR;
    end
  end

  assign push_err = rx_char.break_flag || rx_char.framing_flag || rx_char.parity_flag;
  assign head_err = head_valid && (head.break_flag || head.framing_flag || head.parity_flag);

  uls_fifo #(
    .WIDTH ($bits(uls_rx_char_t)),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .flush     (flush),
    .in_valid  (push),
    .in_data   (push_char),
    .in_ready  (fifo_in_ready),
    .out_valid (head_valid),
    .out_data  (head),
    .out_ready (pop),
    .count     (fifo_cnt)
  );

  // Next state
  always_comb begin
    logic [7:0] status;
    status  = 8'h00;
    next_st = st;
    status[`ULS_LS_DATA_READY] = head_valid;
    status[`ULS_LS_OVERRUN]    = st.overrun;
    // Head flags go straight into the read data register, never held in a status register of their own
    status[`ULS_LS_PARITY]     = head_valid && head.parity_flag;
    status[`ULS_LS_FRAMING]    = head_valid && head.framing_flag;
    status[`ULS_LS_BREAK]      = head_valid && head.break_flag;
    status[`ULS_LS_HOLD_EMPTY] = tx_hold_empty;
    status[`ULS_LS_TX_EMPTY]   = tx_hold_empty && tx_shift_empty;
    status[`ULS_LS_FIFO_ERR]   = st.err_cnt != `ULS_RST_ERR_CNT;

    case (acc)
      ULS_ACC_RD_HOLD: begin
        next_st.rdata = head_valid ? head.data : 8'h00;
      end
      ULS_ACC_RD_STATUS: begin
        next_st.rdata = status;
      end
      ULS_ACC_RD_OTHER: begin
        next_st.rdata = 8'h00;
      end
      ULS_ACC_WR_FCR: begin
        next_st.fifo_en = bus_req.wdata[`ULS_FCR_EN];
      end
      default: begin
      end
    endcase

    // Overrun clears on a status read; a new loss in that cycle wins
    if (acc == ULS_ACC_RD_STATUS) begin
      next_st.overrun = 1'b0;
    end
    if (lost) begin
      next_st.overrun = 1'b1;
    end

    // Flagged entries counted so bit 7 covers the whole FIFO
    if (flush) begin
      next_st.err_cnt = `ULS_RST_ERR_CNT;
    end else begin
      next_st.err_cnt = st.err_cnt + `ULS_ERR_W'(push && push_err)
                        - `ULS_ERR_W'(pop && head_err);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st.rdata   <= `ULS_RST_RDATA;
      st.fifo_en <= `ULS_RST_FIFO_EN;
      st.overrun <= 1'b0;
      st.err_cnt <= `ULS_RST_ERR_CNT;
    end else begin
      st <= next_st;
    end
  end

  assign bus_rdata   = st.rdata;
  assign fifo_enable = st.fifo_en;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Per-slot shadow of the error flags, kept apart from the error counter
  // so the summary bit is held against a second, slot-wise view
  localparam int AW = CW - 1;

  logic [DEPTH-1:0] shadow_err;
  logic [AW-1:0]    shadow_wp;
  logic [AW-1:0]    shadow_rp;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shadow_wp <= '0;
      shadow_rp <= '0;
    end else if (flush) begin
      shadow_wp <= '0;
      shadow_rp <= '0;
    end else begin
      if (push) begin
        shadow_wp <= shadow_wp + AW'(1);
      end
      if (pop) begin
        shadow_rp <= shadow_rp + AW'(1);
      end
    end
  end

  // A push and a pop never hit one slot: that needs a full and empty FIFO at once
  for (genvar g = 0; g < DEPTH; g++) begin : g_shadow
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        shadow_err[g] <= 1'b0;
      end else if (flush) begin
        shadow_err[g] <= 1'b0;
      end else if (push && shadow_wp == AW'(g)) begin
        shadow_err[g] <= push_err;
      end else if (pop && shadow_rp == AW'(g)) begin
        shadow_err[g] <= 1'b0;
      end
    end
  end

  AST_DATA_PRESENT: assert property (
    (acc == ULS_ACC_RD_STATUS)
      |=> bus_rdata[`ULS_LS_DATA_READY] == ($past(fifo_cnt) != '0)
  ) else $error("data-present bit does not match FIFO fill");

  AST_OVERRUN_SET: assert property (
    lost |=> st.overrun ##1 (st.overrun || $past(acc == ULS_ACC_RD_STATUS))
  ) else $error("overrun not flagged after lost character");

  AST_OVERRUN_CLEAR: assert property (
    (acc == ULS_ACC_RD_STATUS && !lost) |=> !st.overrun
  ) else $error("overrun survived a status read");

  AST_OVERRUN_DROP: assert property (
    (lost && !pop && !flush) |=> fifo_cnt == $past(fifo_cnt)
  ) else $error("character written into full receive storage");

  AST_HEAD_FLAGS: assert property (
    (acc == ULS_ACC_RD_STATUS && head_valid)
      |=> bus_rdata[`ULS_LS_BREAK:`ULS_LS_PARITY] ==
          $past({head.break_flag, head.framing_flag, head.parity_flag})
  ) else $error("status bits 4:2 differ from FIFO head flags");

  AST_EMPTY_FLAGS: assert property (
    (acc == ULS_ACC_RD_STATUS && !head_valid)
      |=> bus_rdata[`ULS_LS_BREAK:`ULS_LS_PARITY] == 3'h0 && !bus_rdata[`ULS_LS_DATA_READY]
  ) else $error("error flags shown with an empty receive FIFO");

  AST_SHADOW_HEAD: assert property (
    head_valid |-> shadow_err[shadow_rp] == head_err
  ) else $error("head flags differ from the flags stored with that character");

  AST_BREAK_ZERO: assert property (
    (push && rx_char.break_flag && fifo_cnt == '0)
      |=> head.data == `ULS_BREAK_CHAR && head.break_flag
  ) else $error("break character not stored as zero");

  AST_HOLD_EMPTY_BIT: assert property (
    (acc == ULS_ACC_RD_STATUS)
      |=> bus_rdata[`ULS_LS_HOLD_EMPTY] == $past(tx_hold_empty)
  ) else $error("holding-empty bit wrong");

  AST_TX_EMPTY: assert property (
    (acc == ULS_ACC_RD_STATUS)
      |=> bus_rdata[`ULS_LS_TX_EMPTY] == $past(tx_hold_empty && tx_shift_empty)
  ) else $error("transmit-empty bit wrong");

  AST_SUMMARY: assert property (
    (acc == ULS_ACC_RD_STATUS)
      |=> bus_rdata[`ULS_LS_FIFO_ERR] == $past(|shadow_err)
  ) else $error("summary error bit does not match flagged entries");

  AST_ERR_BOUND: assert property (
    st.err_cnt <= `ULS_ERR_W'(DEPTH)
  ) else $error("error count exceeds the FIFO depth");

  AST_STATUS_NO_POP: assert property (
    (acc == ULS_ACC_RD_STATUS && !push && !flush) |=> fifo_cnt == $past(fifo_cnt)
  ) else $error("status read moved the receive FIFO");

  AST_STATUS_HEAD_KEPT: assert property (
    (acc == ULS_ACC_RD_STATUS && head_valid && !flush) |=> head == $past(head)
  ) else $error("status read changed the FIFO head");

  AST_POP_ONLY_HOLD: assert property (
    (fifo_cnt < $past(fifo_cnt)) |-> $past(acc == ULS_ACC_RD_HOLD) || $past(flush)
  ) else $error("receive FIFO advanced without a data read");

  AST_HOLD_DATA: assert property (
    (acc == ULS_ACC_RD_HOLD && head_valid) |=> bus_rdata == $past(head.data)
  ) else $error("data read did not return the FIFO head");

  AST_HOLD_POP: assert property (
    (acc == ULS_ACC_RD_HOLD && head_valid && !push && !flush)
      |=> fifo_cnt == $past(fifo_cnt) - CW'(1)
  ) else $error("data read did not remove exactly one character");

  AST_FIFO_OFF: assert property (
    !st.fifo_en |-> fifo_cnt <= CW'(1)
  ) else $error("more than one character held with FIFO disabled");

  AST_FLUSH_EMPTY: assert property (
    flush |=> fifo_cnt == '0 && st.err_cnt == `ULS_RST_ERR_CNT
  ) else $error("receive FIFO not emptied by a reset or mode change");

  AST_ENABLE_WRITE: assert property (
    (acc == ULS_ACC_WR_FCR) |=> st.fifo_en == $past(bus_req.wdata[`ULS_FCR_EN])
  ) else $error("FIFO enable bit not taken from the control write");

  COV_OVERRUN: cover property (lost ##[1:20] (acc == ULS_ACC_RD_STATUS));
  COV_FULL:    cover property (st.fifo_en && fifo_cnt == CW'(DEPTH));
  COV_ERR_POP: cover property ((acc == ULS_ACC_RD_STATUS && head_err) ##[1:10] pop);
  COV_FLUSH:   cover property (flush && head_valid);

endmodule

// *** tb/uls_host_model.sv ***
// Host processor model driving single-cycle register accesses
`timescale 1ns/1ps
module uls_host_model
  import uls_pkg::*;
(
  // Clock
  input  wire logic         clk,
  // Register bus
  output      uls_bus_req_t bus_req,
  input  wire logic [7:0]   bus_rdata
);
  initial begin
    bus_req = '0;
  end

  // One strobe cycle per access; answer is read after the taking edge
  task automatic access(input logic rd, input logic [2:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    @(posedge clk);
    bus_req <= '{cs: 1'b1, rd: rd, wr: ~rd, addr: addr, wdata: wdata};
    @(posedge clk);
    // Idle lines toggle so a stale address is never mistaken for a live one
    bus_req <= '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    #1;
    rdata = bus_rdata;
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the line status block
`timescale 1ns/1ps
`include "uls_map.svh"
module testbench
  import uls_pkg::*;
;
  logic         clk;
  logic         nrst;
  uls_bus_req_t bus_req;
  logic [7:0]   bus_rdata;
  logic         rx_valid;
  uls_rx_char_t rx_char;
  logic         tx_hold_empty;
  logic         tx_shift_empty;
  logic         fifo_enable;
  int           err_total;
  int           n_tests;
  logic [7:0]   dummy;
  logic [2:0]   flg [4];
  logic [7:0]   dat [4];

  uls_line_status #(.DEPTH(`ULS_FIFO_DEPTH)) DUT (
    .clk            (clk),
    .nrst           (nrst),
    .bus_req        (bus_req),
    .bus_rdata      (bus_rdata),
    .rx_valid       (rx_valid),
    .rx_char        (rx_char),
    .tx_hold_empty  (tx_hold_empty),
    .tx_shift_empty (tx_shift_empty),
    .fifo_enable    (fifo_enable)
  );

  uls_host_model host (
    .clk       (clk),
    .bus_req   (bus_req),
    .bus_rdata (bus_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Expected status with both transmit stages empty
  function automatic logic [7:0] status_exp(input logic dr, input logic oe,
                                            input logic [2:0] bfp, input logic er);
    return {er, 2'b11, bfp, oe, dr};
  endfunction

  task automatic rdc(input string name, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.access(1'b1, a, 8'h00, d);
    chk(name, d, exp);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    host.access(1'b0, a, v, dummy);
  endtask

  task automatic push(input logic [2:0] bfp, input logic [7:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char  <= {bfp, d};
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char  <= ~rx_char;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial begin
    err_total      = 0;
    n_tests        = 0;
    nrst           = 1'b0;
    rx_valid       = 1'b0;
    rx_char        = '0;
    tx_hold_empty  = 1'b1;
    tx_shift_empty = 1'b1;
    flg = '{3'b000, 3'b001, 3'b010, 3'b100};
    dat = '{8'h41, 8'h52, 8'h63, `ULS_BREAK_CHAR};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    // After reset
    rdc("status_reset", `ULS_ADDR_LINE_STATUS, 8'h60);
    rdc("hold_read_empty", `ULS_ADDR_RX_HOLD, 8'h00);
    chk("fifo_enable_reset", {7'h00, fifo_enable}, 8'h00);
    // Transmit status bits over all four combinations
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      tx_hold_empty  <= i[0];
      tx_shift_empty <= i[1];
      rdc("status_tx", `ULS_ADDR_LINE_STATUS, {1'b0, i[0] & i[1], i[0], 5'h00});
    end
    @(posedge clk);
    tx_hold_empty  <= 1'b1;
    tx_shift_empty <= 1'b1;
    // Disabled FIFO holds one character; second one overruns
    push(3'b001, 8'hA5);
    push(3'b000, 8'h5A);
    rdc("status_one", `ULS_ADDR_LINE_STATUS, status_exp(1'b1, 1'b1, 3'b001, 1'b1));
    rdc("hold_one", `ULS_ADDR_RX_HOLD, 8'hA5);
    rdc("status_one_empty", `ULS_ADDR_LINE_STATUS, 8'h60);
    // Enabled FIFO: fill to the brim plus one
    wr(`ULS_ADDR_FCR, 8'h01);
    chk("fifo_enable_on", {7'h00, fifo_enable}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      push(flg[i], dat[i]);
    end
    push(3'b000, 8'h7E);
    for (int i = 0; i < 4; i++) begin
      rdc("status_head", `ULS_ADDR_LINE_STATUS,
          status_exp(1'b1, i == 0, flg[i], 1'b1));
      if (i == 0) begin
        rdc("status_again", `ULS_ADDR_LINE_STATUS,
            status_exp(1'b1, 1'b0, flg[0], 1'b1));
      end
      rdc("hold_head", `ULS_ADDR_RX_HOLD, dat[i]);
    end
    rdc("status_drained", `ULS_ADDR_LINE_STATUS, 8'h60);
    // Clean character behind a flagged one clears the summary once popped
    push(3'b010, 8'h21);
    push(3'b000, 8'h22);
    rdc("hold_flagged", `ULS_ADDR_RX_HOLD, 8'h21);
    rdc("status_clean_head", `ULS_ADDR_LINE_STATUS,
        status_exp(1'b1, 1'b0, 3'b000, 1'b0));
    // Receive FIFO reset empties storage and errors
    push(3'b100, `ULS_BREAK_CHAR);
    wr(`ULS_ADDR_FCR, 8'h03);
    rdc("status_flushed", `ULS_ADDR_LINE_STATUS, 8'h60);
    wr(3'h3, 8'h00);
    chk("fifo_enable_kept", {7'h00, fifo_enable}, 8'h01);
    rdc("unmapped", 3'h7, 8'h00);
    wr(`ULS_ADDR_FCR, 8'h00);
    chk("fifo_enable_off", {7'h00, fifo_enable}, 8'h00);
    // Reset in mid-run clears stored status and the enable bit
    wr(`ULS_ADDR_FCR, 8'h01);
    push(3'b011, 8'h33);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdc("status_rereset", `ULS_ADDR_LINE_STATUS, 8'h60);
    chk("fifo_enable_rereset", {7'h00, fifo_enable}, 8'h00);
    conclude();
  end
endmodule
